/* rtl/dma_defines.svh */
// register offsets, field positions and reset values of the peripheral dma channel block
//
// Behaviour
// - a failed memory access sets the channel error flag and stops that channel
// - with the error interrupt unmasked, the channel interrupt rises on an error
// - each channel owns a 0x040 byte window at base plus channel times 0x040
// - memory address holds buffer start, then always the next location to access
// - writing the peripheral identifier selects handshake, direction and holding register
// - peripheral identifier width is a build parameter from the peripheral count
// - the 16-bit count is programmed with items and shows items still outstanding
// - count reaching zero with non-zero count reload copies the address reload
// - at that moment the count loads from the count reload when it is above zero
// - count reload zero when the count reaches zero ends transfers on the channel
// - every reload of the count from its reload register clears that reload register
// - peripheral select resets to a per-channel value, not a fixed zero
// - address advances by one, two or four for byte, halfword or word items
// - non-zero count written on an enabled channel starts transfers, one decrement per item
// - writing count reload while the count is zero loads count and address directly
// - simultaneous requests are granted to the lowest numbered channel first
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

// ****************************************************************
// channel window
// ****************************************************************
`define CH_WIN_BITS             6
`define OFF_MEMORY_ADDRESS      6'h00
`define OFF_PERIPHERAL_SELECT   6'h04
`define OFF_TRANSFER_COUNT      6'h08
`define OFF_ADDRESS_RELOAD      6'h0C
`define OFF_COUNT_RELOAD        6'h10
`define OFF_CONTROL_STROBES     6'h14
`define OFF_MODE_CONFIG         6'h18
`define OFF_CHANNEL_STATUS      6'h1C
`define OFF_IRQ_ENABLE_SET      6'h20
`define OFF_IRQ_ENABLE_CLEAR    6'h24
`define OFF_IRQ_MASK            6'h28
`define OFF_IRQ_STATUS          6'h2C

// ****************************************************************
// field positions
// ****************************************************************
`define CTL_ENABLE_BIT          0
`define CTL_DISABLE_BIT         1
`define CTL_ERR_CLEAR_BIT       8
`define STAT_ENABLED_BIT        0
`define IRQ_RELOAD_ZERO_BIT     0
`define IRQ_COMPLETE_BIT        1
`define IRQ_ERROR_BIT           2
`define IRQ_BITS                3

// ****************************************************************
// transfer sizes and reset values
// ****************************************************************
`define SIZE_BYTE               2'h0
`define SIZE_HALF               2'h1
`define SIZE_WORD               2'h2
`define RESET_WORD              32'h0000_0000

`endif

/* rtl/dma_pkg.sv */
// shared types of the peripheral dma channel block
package dma_pkg;

  // item sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PER_RD,
    ST_MEM_RD,
    ST_PER_WR
  } xfer_state_t;

endpackage : dma_pkg

/* rtl/dma_fifo.sv */
// synchronous valid/ready fifo for posted memory writes
`timescale 1ns/1ns
module dma_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
    $error("dma_fifo needs a power of two depth of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  // handshakes from the fill level
  assign in_ready  = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state of pointers and storage
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : dma_fifo

/* rtl/periph_dma_channel_regs.sv */
// multi-channel peripheral dma: channel registers, reload, arbitration and item mover
`timescale 1ns/1ns
`include "dma_defines.svh"
module periph_dma_channel_regs
  import dma_pkg::*;
#(
  parameter  int NUM_CH     = 7,
  parameter  int NUM_PERIPH = 14,
  parameter  int RX_PIDS    = 7,
  parameter  int FIFO_DEPTH = 8,
  localparam int CH_W       = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
  localparam int PID_W      = $clog2(NUM_PERIPH),
  localparam int ADDR_W     = CH_W + `CH_WIN_BITS
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [NUM_PERIPH-1:0] hs_req,
  output logic [NUM_PERIPH-1:0]  hs_ack,
  output logic [PID_W-1:0]       per_sel,
  output logic                   per_read,
  input  wire logic [31:0]       per_rdata,
  output logic                   per_write,
  output logic [31:0]            per_wdata,
  output logic [31:0]            mem_address,
  output logic [1:0]             mem_size,
  output logic                   mem_read,
  output logic                   mem_write,
  output logic [31:0]            mem_writedata,
  input  wire logic [31:0]       mem_readdata,
  input  wire logic              mem_waitrequest,
  input  wire logic              mem_error,
  output logic [NUM_CH-1:0]      irq
);
  localparam int FW = CH_W + 2 + 64;

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (NUM_CH < 1 || NUM_CH > 16 || NUM_PERIPH < 2 || RX_PIDS > NUM_PERIPH) begin : g_bad
    $error("periph_dma_channel_regs parameters out of range");
  end

  typedef struct packed {
    logic [NUM_CH-1:0][31:0]      memory_address;
    logic [NUM_CH-1:0][PID_W-1:0] periph_ident;
    logic [NUM_CH-1:0][15:0]      transfer_count;
    logic [NUM_CH-1:0][31:0]      address_reload;
    logic [NUM_CH-1:0][15:0]      count_reload;
    logic [NUM_CH-1:0]            chan_en;
    logic [NUM_CH-1:0][1:0]       xfer_size;
    logic [NUM_CH-1:0][2:0]       irq_mask;
    logic [NUM_CH-1:0]            xfer_error_flag;
    xfer_state_t                  st;
    logic [CH_W-1:0]              cur;
    logic [31:0]                  addr;
    logic [1:0]                   cur_size;
    logic [PID_W-1:0]             sel;
    logic [31:0]                  data;
    logic [31:0]                  rdata;
    logic                         rdv;
  } dma_state_t;

  dma_state_t      s_r;
  dma_state_t      s_nxt;
  logic [NUM_CH-1:0] elig;
  logic            gnt_valid;
  logic [CH_W-1:0] gnt_ch;
  logic            fi_ready;
  logic            fo_valid;
  logic            fo_ready;
  logic [FW-1:0]   fi_data;
  logic [FW-1:0]   fo_data;
  logic [CH_W-1:0] fo_ch;
  logic [1:0]      fo_size;
  logic [31:0]     fo_addr;
  logic [31:0]     fo_wdata;
  logic            rd_phase;
  logic            mem_fail;
  logic [CH_W-1:0] fail_ch;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] step(input logic [1:0] sz);
    if (sz == `SIZE_BYTE) begin
      step = 32'h0000_0001;
    end else if (sz == `SIZE_HALF) begin
      step = 32'h0000_0002;
    end else begin
      step = 32'h0000_0004;
    end
  endfunction : step

  function automatic logic [31:0] fit(input logic [31:0] d, input logic [1:0] sz);
    if (sz == `SIZE_BYTE) begin
      fit = {24'h00_0000, d[7:0]};
    end else if (sz == `SIZE_HALF) begin
      fit = {16'h0000, d[15:0]};
    end else begin
      fit = d;
    end
  endfunction : fit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  function automatic logic is_tx(input logic [PID_W-1:0] id);
    is_tx = int'(id) >= RX_PIDS;
  endfunction : is_tx

  // ****************************************************************
  // posted write buffer and memory port
  // ****************************************************************
  assign fi_data  = {s_r.cur, s_r.cur_size, s_r.addr, fit(per_rdata, s_r.cur_size)};
  assign {fo_ch, fo_size, fo_addr, fo_wdata} = fo_data;

  dma_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (s_r.st == ST_PER_RD),
    .in_ready  (fi_ready),
    .in_data   (fi_data),
    .out_valid (fo_valid),
    .out_ready (fo_ready),
    .out_data  (fo_data)
  );

  // memory port: sequencer reads, else drains buffered writes
  assign rd_phase      = s_r.st == ST_MEM_RD;
  assign mem_read      = rd_phase;
  assign mem_write     = fo_valid && !rd_phase;
  assign mem_address   = rd_phase ? s_r.addr : fo_addr;
  assign mem_size      = rd_phase ? s_r.cur_size : fo_size;
  assign mem_writedata = fo_wdata;
  assign fo_ready      = mem_write && !mem_waitrequest;
  assign mem_fail      = (rd_phase || mem_write) && !mem_waitrequest && mem_error;
  assign fail_ch       = rd_phase ? s_r.cur : fo_ch;

  // peripheral side and bus answers
  assign per_sel         = s_r.sel;
  assign per_read        = s_r.st == ST_PER_RD;
  assign per_write       = s_r.st == ST_PER_WR;
  assign per_wdata       = s_r.data;
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = avs_read && !s_r.rdv;

  // ****************************************************************
  // eligibility, fixed priority grant, acknowledge
  // ****************************************************************
  always_comb begin
    elig      = '0;
    gnt_valid = 1'b0;
    gnt_ch    = '0;
    hs_ack    = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      // a stopped, disabled or empty channel never asks
      elig[i] = s_r.chan_en[i] && !s_r.xfer_error_flag[i] && s_r.transfer_count[i] != 16'h0000
                && int'(s_r.periph_ident[i]) < NUM_PERIPH && hs_req[s_r.periph_ident[i]]
                && (is_tx(s_r.periph_ident[i]) ? !fo_valid : fi_ready);
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (elig[i] && s_r.st == ST_IDLE) begin
        gnt_valid = 1'b1;
        gnt_ch    = CH_W'(i);
      end
    end
    if (gnt_valid) begin
      hs_ack[s_r.periph_ident[gnt_ch]] = 1'b1;
    end
  end

  // interrupt lines from status and mask
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      irq[i] = |({s_r.xfer_error_flag[i],
                  s_r.transfer_count[i] == 16'h0000 && s_r.count_reload[i] == 16'h0000,
                  s_r.count_reload[i] == 16'h0000} & s_r.irq_mask[i]);
    end
  end

  // ****************************************************************
  // next state: counters, registers, sequencer
  // ****************************************************************
  always_comb begin
    logic [CH_W-1:0] c;
    logic [5:0]      off;
    logic            hit;
    logic [31:0]     wd;
    logic [31:0]     rd;
    c     = avs_address[ADDR_W-1:`CH_WIN_BITS];
    off   = avs_address[`CH_WIN_BITS-1:0];
    hit   = int'(c) < NUM_CH;
    wd    = avs_writedata & merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable);
    rd    = 32'h0000_0000;
    s_nxt = s_r;
    for (int i = 0; i < NUM_CH; i++) begin
      // item start: advance pointer, count down, reload at zero
      if (gnt_valid && gnt_ch == CH_W'(i)) begin
        s_nxt.memory_address[i] = s_r.memory_address[i] + step(s_r.xfer_size[i]);
        if (s_r.transfer_count[i] != 16'h0001) begin
          s_nxt.transfer_count[i] = s_r.transfer_count[i] - 16'h0001;
        end else if (s_r.count_reload[i] != 16'h0000) begin
          s_nxt.memory_address[i] = s_r.address_reload[i];
          s_nxt.transfer_count[i] = s_r.count_reload[i];
          s_nxt.count_reload[i]   = 16'h0000;
          s_nxt.address_reload[i] = `RESET_WORD;
        end else begin
          s_nxt.transfer_count[i] = 16'h0000;
        end
      end
      // software writes take precedence over the item update
      if (avs_write && hit && c == CH_W'(i)) begin
        if (off == `OFF_MEMORY_ADDRESS) begin
          s_nxt.memory_address[i] = merge(s_r.memory_address[i], avs_writedata, avs_byteenable);
        end else if (off == `OFF_PERIPHERAL_SELECT) begin
          s_nxt.periph_ident[i] = wd[PID_W-1:0];
        end else if (off == `OFF_TRANSFER_COUNT) begin
          s_nxt.transfer_count[i] = 16'(merge({16'h0000, s_r.transfer_count[i]}, wd,
                                              avs_byteenable));
        end else if (off == `OFF_ADDRESS_RELOAD) begin
          s_nxt.address_reload[i] = merge(s_r.address_reload[i], avs_writedata, avs_byteenable);
        end else if (off == `OFF_COUNT_RELOAD) begin
          if (s_r.transfer_count[i] == 16'h0000) begin
            s_nxt.transfer_count[i] = wd[15:0];
            s_nxt.memory_address[i] = s_r.address_reload[i];
            s_nxt.count_reload[i]   = 16'h0000;
            s_nxt.address_reload[i] = `RESET_WORD;
          end else begin
            s_nxt.count_reload[i] = 16'(merge({16'h0000, s_r.count_reload[i]}, wd, avs_byteenable));
          end
        end else if (off == `OFF_CONTROL_STROBES) begin
          if (wd[`CTL_ENABLE_BIT]) begin
            s_nxt.chan_en[i] = 1'b1;
          end
          if (wd[`CTL_DISABLE_BIT]) begin
            s_nxt.chan_en[i] = 1'b0;
          end
          if (wd[`CTL_ERR_CLEAR_BIT]) begin
            s_nxt.xfer_error_flag[i] = 1'b0;
          end
        end else if (off == `OFF_MODE_CONFIG) begin
          s_nxt.xfer_size[i] = wd[1:0];
        end else if (off == `OFF_IRQ_ENABLE_SET) begin
          s_nxt.irq_mask[i] = s_r.irq_mask[i] | wd[`IRQ_BITS-1:0];
        end else if (off == `OFF_IRQ_ENABLE_CLEAR) begin
          s_nxt.irq_mask[i] = s_r.irq_mask[i] & ~wd[`IRQ_BITS-1:0];
        end
      end
      // a new error wins over a clear in the same cycle
      if (mem_fail && fail_ch == CH_W'(i)) begin
        s_nxt.xfer_error_flag[i] = 1'b1;
      end
    end
    // register read, answered one cycle later
    if (hit) begin
      if (off == `OFF_MEMORY_ADDRESS) begin
        rd = s_r.memory_address[c];
      end else if (off == `OFF_PERIPHERAL_SELECT) begin
        rd = 32'(s_r.periph_ident[c]);
      end else if (off == `OFF_TRANSFER_COUNT) begin
        rd = {16'h0000, s_r.transfer_count[c]};
      end else if (off == `OFF_ADDRESS_RELOAD) begin
        rd = s_r.address_reload[c];
      end else if (off == `OFF_COUNT_RELOAD) begin
        rd = {16'h0000, s_r.count_reload[c]};
      end else if (off == `OFF_MODE_CONFIG) begin
        rd = {30'h0000_0000, s_r.xfer_size[c]};
      end else if (off == `OFF_CHANNEL_STATUS) begin
        rd = {31'h0000_0000, s_r.chan_en[c]};
      end else if (off == `OFF_IRQ_MASK) begin
        rd = {29'h0000_0000, s_r.irq_mask[c]};
      end else if (off == `OFF_IRQ_STATUS) begin
        rd = {29'h0000_0000, s_r.xfer_error_flag[c],
              s_r.transfer_count[c] == 16'h0000 && s_r.count_reload[c] == 16'h0000,
              s_r.count_reload[c] == 16'h0000};
      end
    end
    s_nxt.rdv = avs_read && !s_r.rdv;
    if (avs_read && !s_r.rdv) begin
      s_nxt.rdata = rd;
    end
    // item sequencer
    case (s_r.st)
      ST_IDLE: begin
        if (gnt_valid) begin
          s_nxt.cur      = gnt_ch;
          s_nxt.addr     = s_r.memory_address[gnt_ch];
          s_nxt.cur_size = s_r.xfer_size[gnt_ch];
          s_nxt.sel      = s_r.periph_ident[gnt_ch];
          s_nxt.st       = is_tx(s_r.periph_ident[gnt_ch]) ? ST_MEM_RD : ST_PER_RD;
        end
      end
      ST_PER_RD: begin
        s_nxt.st = ST_IDLE;
      end
      ST_MEM_RD: begin
        if (!mem_waitrequest) begin
          s_nxt.data = fit(mem_readdata, s_r.cur_size);
          s_nxt.st   = mem_error ? ST_IDLE : ST_PER_WR;
        end
      end
      ST_PER_WR: begin
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // state register; peripheral select resets to the channel number
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        s_r.periph_ident[i] <= PID_W'(i);
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  read_error_stop_a: assert property (
    (rd_phase && !mem_waitrequest && mem_error)
    |=> s_r.xfer_error_flag[$past(s_r.cur)] && s_r.st == ST_IDLE)
    else $error("read error did not stop the channel");

  no_grant_err_a: assert property (
    gnt_valid |-> !s_r.xfer_error_flag[gnt_ch] && s_r.chan_en[gnt_ch])
    else $error("stopped channel was granted");

  irq_on_error_a: assert property (
    (s_r.xfer_error_flag[0] && s_r.irq_mask[0][`IRQ_ERROR_BIT]) |-> irq[0])
    else $error("error interrupt missing");

  window_read_a: assert property (
    (avs_read && !s_r.rdv && avs_address == ADDR_W'(`OFF_TRANSFER_COUNT) + ADDR_W'(64))
    |=> !avs_waitrequest && avs_readdata == {16'h0000, $past(s_r.transfer_count[1])})
    else $error("channel one window read wrong");

  addr_step_a: assert property (
    (gnt_valid && s_r.transfer_count[gnt_ch] != 16'h0001 && !avs_write)
    |=> s_r.memory_address[$past(gnt_ch)]
        == $past(s_r.memory_address[gnt_ch]) + step($past(s_r.xfer_size[gnt_ch])))
    else $error("pointer did not advance by item size");

  count_dec_a: assert property (
    (gnt_valid && s_r.transfer_count[gnt_ch] > 16'h0001 && !avs_write)
    |=> s_r.transfer_count[$past(gnt_ch)] == $past(s_r.transfer_count[gnt_ch]) - 16'h0001)
    else $error("count did not decrement once");

  reload_a: assert property (
    (gnt_valid && s_r.transfer_count[gnt_ch] == 16'h0001 && s_r.count_reload[gnt_ch] != 16'h0000
     && !avs_write)
    |=> s_r.transfer_count[$past(gnt_ch)] == $past(s_r.count_reload[gnt_ch])
        && s_r.memory_address[$past(gnt_ch)] == $past(s_r.address_reload[gnt_ch])
        && s_r.count_reload[$past(gnt_ch)] == 16'h0000)
    else $error("reload did not take place");

  empty_stop_a: assert property (
    gnt_valid |-> s_r.transfer_count[gnt_ch] != 16'h0000)
    else $error("empty channel was granted");

  lowest_first_a: assert property (
    gnt_valid |-> (elig & ((NUM_CH)'(1) << gnt_ch) - (NUM_CH)'(1)) == '0)
    else $error("higher channel beat a lower one");

  ack_grant_a: assert property (
    (|hs_ack) |-> gnt_valid && $onehot(hs_ack) && hs_ack[s_r.periph_ident[gnt_ch]])
    else $error("acknowledge without a grant");

  direct_load_a: assert property (
    (avs_write && avs_address == ADDR_W'(`OFF_COUNT_RELOAD) && avs_byteenable == 4'hF
     && s_r.transfer_count[0] == 16'h0000)
    |=> s_r.transfer_count[0] == $past(avs_writedata[15:0])
        && s_r.memory_address[0] == $past(s_r.address_reload[0]))
    else $error("direct load from reload values missing");

  rx_item_c: cover property (s_r.st == ST_PER_RD ##[1:20] fo_ready);
  tx_item_c: cover property (s_r.st == ST_MEM_RD ##[1:20] s_r.st == ST_PER_WR);
  reload_c:  cover property (gnt_valid && s_r.transfer_count[gnt_ch] == 16'h0001
                             && s_r.count_reload[gnt_ch] != 16'h0000);
  error_c:   cover property (mem_fail);

endmodule : periph_dma_channel_regs

/* test/periph_model.sv */
// peripheral handshake and memory slave model at the far side of the dma block
`timescale 1ns/1ns
module periph_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  go,
  input  wire logic [13:0] hs_ack,
  output logic [13:0]      hs_req,
  input  wire logic        per_read,
  output logic [31:0]      per_rdata,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_address,
  output logic [31:0]      mem_readdata,
  output logic             mem_waitrequest,
  output logic             mem_error
);
  logic [7:0] pend_r;
  logic [7:0] sent_r;
  logic       ack_r;
  // ****************************************************************
  // request and memory answer state
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_r <= 8'h00;
      sent_r <= 8'h00;
      ack_r  <= 1'b0;
    end else begin
      pend_r <= pend_r + {4'h0, go} - {7'h00, |hs_ack};
      sent_r <= sent_r + {7'h00, per_read};
      ack_r  <= (mem_read | mem_write) & !ack_r;
    end
  end
  // request held until acknowledged; data inverted when not read
  assign hs_req          = {14{pend_r != 8'h00}};
  assign per_rdata       = per_read ? {24'hA50000, sent_r} : ~{24'hA50000, sent_r};
  assign mem_waitrequest = !ack_r;
  assign mem_readdata    = ack_r ? ~mem_address : mem_address;
  assign mem_error       = ack_r & (mem_address[31:28] == 4'hF); // faulty region
endmodule : periph_model

/* test/testbench.sv */
// self-checking bench of the peripheral dma channel block
`timescale 1ns/1ns
module testbench;
  logic        core_clk, reset, avs_read, avs_write, avs_waitrequest, per_read, per_write;
  logic        mem_read, mem_write, mem_waitrequest, mem_error;
  logic [8:0]  avs_address;
  logic [3:0]  avs_byteenable, per_sel, go;
  logic [13:0] hs_req, hs_ack;
  logic [1:0]  mem_size;
  logic [6:0]  irq;
  logic [31:0] avs_writedata, avs_readdata, per_rdata, per_wdata, mem_address, mem_writedata, mem_readdata, q;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  logic [35:0] pw;
  int          n_mismatch = 0;
  int          num_checks = 0;
  typedef struct packed {logic w; logic [8:0] wa; logic [31:0] d; logic [8:0] ra; logic [31:0] e;} row_t;
  row_t rows[9] = '{
    '{1'b0, 9'h000, 32'h0, 9'h000, 32'h0},
    '{1'b0, 9'h000, 32'h0, 9'h048, 32'h0},
    '{1'b0, 9'h000, 32'h0, 9'h0C4, 32'h3},
    '{1'b0, 9'h000, 32'h0, 9'h184, 32'h6},
    '{1'b0, 9'h000, 32'h0, 9'h1C4, 32'h0},
    '{1'b1, 9'h040, 32'hDEADBEEF, 9'h040, 32'hDEADBEEF},
    '{1'b1, 9'h058, 32'hFFFFFFFF, 9'h058, 32'h3},
    '{1'b1, 9'h060, 32'h4, 9'h068, 32'h4},
    '{1'b1, 9'h084, 32'hFFFFFFFF, 9'h084, 32'hF}};
  periph_dma_channel_regs uut (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .hs_req, .hs_ack, .per_sel, .per_read, .per_rdata,
    .per_write, .per_wdata, .mem_address, .mem_size, .mem_read, .mem_write, .mem_writedata,
    .mem_readdata, .mem_waitrequest, .mem_error, .irq);
  periph_model far (.core_clk, .reset, .go, .hs_ack, .hs_req, .per_read, .per_rdata, .mem_read,
    .mem_write, .mem_address, .mem_readdata, .mem_waitrequest, .mem_error);
  // ****************************************************************
  // clock, write log and shared tasks
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mem_write === 1'b1 && mem_waitrequest === 1'b0) begin
      wa.push_back(mem_address);
      wd.push_back(mem_writedata);
    end
    if (per_write === 1'b1) pw <= {per_sel, per_wdata};
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : bus
  task automatic wait_wr(input int n);
    for (int i = 0; i < 200 && wa.size() < n; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(32'(wa.size()), 32'(n));
  endtask : wait_wr
  task automatic items(input logic [3:0] n);
    go <= n;
    @(posedge core_clk);
    go <= 4'h0;
  endtask : items
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata, go} = {1'b1, 47'h0};
    avs_byteenable = 4'hF;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].wa, rows[i].d);
      bus(1'b0, rows[i].ra, 32'h0);
      chk(q, rows[i].e);
    end
    $display("register rows done");
    bus(1'b1, 9'h018, 32'h2);
    bus(1'b1, 9'h000, 32'h100);
    bus(1'b1, 9'h008, 32'h2);
    bus(1'b1, 9'h00C, 32'h200);
    bus(1'b1, 9'h010, 32'h1);
    bus(1'b1, 9'h020, 32'h4);
    bus(1'b1, 9'h014, 32'h1);
    items(4'h4);
    wait_wr(3);
    chk(wa[0], 32'h100);
    chk(wa[1], 32'h104);
    chk(wa[2], 32'h200);
    chk(wd[0], 32'hA5000000);
    bus(1'b0, 9'h008, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 9'h010, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 9'h000, 32'h0);
    chk(q, 32'h204);
    repeat (30) @(posedge core_clk);
    chk(32'(wa.size()), 32'h3);
    $display("reload test done");
    bus(1'b1, 9'h00C, 32'hF0000000);
    bus(1'b1, 9'h010, 32'h1);
    wait_wr(4);
    chk(wa[3], 32'hF0000000);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq[0]}, 32'h1);
    bus(1'b0, 9'h02C, 32'h0);
    chk(q & 32'h4, 32'h4);
    bus(1'b1, 9'h000, 32'h300);
    bus(1'b1, 9'h008, 32'h1);
    items(4'h1);
    repeat (30) @(posedge core_clk);
    chk(32'(wa.size()), 32'h4);
    bus(1'b1, 9'h014, 32'h100);
    wait_wr(5);
    chk(wa[4], 32'h300);
    $display("error test done");
    bus(1'b1, 9'h004, 32'h7);
    bus(1'b1, 9'h018, 32'h0);
    bus(1'b1, 9'h000, 32'h400);
    bus(1'b1, 9'h008, 32'h1);
    items(4'h1);
    repeat (20) @(posedge core_clk);
    chk({28'h0, pw[35:32]}, 32'h7);
    chk(pw[31:0], 32'hFF);
    bus(1'b0, 9'h000, 32'h0);
    chk(q, 32'h401);
    $display("transmit test done");
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, 9'h004, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 9'h084, 32'h0);
    chk(q, 32'h2);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : testbench
